// file: core/fnvcl_config_loader.sv
`timescale 1ns/1ns
module fnvcl_config_loader #(
	parameter int         POR_FULL_CYCLES   = fnvcl_pkg::FULL_POR_CYCLES,
	parameter int         POR_SECOND_CYCLES = fnvcl_pkg::FULL_POR_CYCLES,
	parameter logic [7:0] OP_WRITE_ENABLE   = 8'h01,
	parameter logic [7:0] OP_STATUS_READ    = 8'h02,
	parameter logic [7:0] OP_FLAG_READ      = 8'h03,
	parameter logic [7:0] OP_SINGLE_FAST    = 8'h10,
	parameter logic [7:0] OP_DUAL_OUT       = 8'h11,
	parameter logic [7:0] OP_DUAL_IO        = 8'h12,
	parameter logic [7:0] OP_QUAD_OUT       = 8'h13,
	parameter logic [7:0] OP_QUAD_IO        = 8'h14
) (
	// Clock, reset and enable
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        ce_in,
	// Register port
	input  wire logic [3:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic [15:0]      reg_rdata_out,
	// Stored word from the array and programming path
	input  wire logic [15:0] nv_store_in,
	output logic [15:0]      nv_program_out,
	output logic             nv_program_stb_out,
	// Serial link pins
	input  wire logic        sclk_in,
	input  wire logic        cs_n_in,
	input  wire logic [3:0]  dq_in,
	// Working configuration and link status
	output logic [3:0]       dummy_count_out,
	output logic [2:0]       xip_mode_out,
	output logic [2:0]       drive_strength_out,
	output logic             hold_enable_out,
	output logic [1:0]       protocol_out,
	output logic             hold_active_out,
	output logic             cmd_accept_out,
	output logic             cmd_reject_out,
	output logic             read_data_out,
	output logic             read_corrupt_out
);

	typedef enum logic [2:0] {
		FNVCL_POR_LOAD   = 3'b000,
		FNVCL_POR_BOOT   = 3'b001,
		FNVCL_POR_RDONLY = 3'b011,
		FNVCL_POR_SECOND = 3'b010,
		FNVCL_POR_FULL   = 3'b110
	} fnvcl_por_t;

	typedef enum logic [2:0] {
		FNVCL_LK_IDLE  = 3'b000,
		FNVCL_LK_CMD   = 3'b001,
		FNVCL_LK_ADDR  = 3'b011,
		FNVCL_LK_DUMMY = 3'b010,
		FNVCL_LK_DATA  = 3'b110,
		FNVCL_LK_SKIP  = 3'b100
	} fnvcl_link_t;

	fnvcl_por_t              por_q;
	fnvcl_link_t             link_q;
	fnvcl_pkg::fnvcl_read_t  variant_q;
	logic [21:0]             timer_q;
	logic [15:0]             active_q;
	logic [15:0]             nv_q;
	logic [21:0]             nv_meta_q;
	logic [21:0]             nv_sync_q;
	logic                    sclk_prev_q;
	logic [4:0]              bit_cnt_q;
	logic [7:0]              shift_q;
	logic [7:0]              period_q;
	logic [7:0]              period_cnt_q;
	logic                    overclock_q;
	logic                    dummy_start;
	logic                    dummy_done;
	logic                    sclk_s;
	logic                    cs_n_s;
	logic [3:0]              dq_s;
	logic                    sclk_rise;
	logic                    cs_fall;
	logic [2:0]              lines;
	logic [7:0]              shift_next;
	logic [4:0]              cmd_clks;
	logic [4:0]              addr_clks;
	logic                    xip_on;
	logic                    link_busy;
	logic [7:0]              op;
	logic [3:0]              tbl_idx;
	logic [21:0]             limit_ns;

	// Pins and the stored word each pass two flip-flops before use.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			// The serial clock bit resets to its idle low level, so no false edge follows.
			nv_meta_q <= {6'h1f, fnvcl_pkg::NV_DEFAULT};
			nv_sync_q <= {6'h1f, fnvcl_pkg::NV_DEFAULT};
		end else if (ce_in) begin
			nv_meta_q <= {sclk_in, cs_n_in, dq_in, nv_store_in};
			nv_sync_q <= nv_meta_q;
		end
	end

	assign sclk_s    = nv_sync_q[21];
	assign cs_n_s    = nv_sync_q[20];
	assign dq_s      = nv_sync_q[19:16];
	assign sclk_rise = sclk_s && !sclk_prev_q && !cs_n_s && !hold_active_out;
	assign cs_fall   = !cs_n_s && sclk_prev_q == sclk_s && link_q == FNVCL_LK_IDLE;
	assign xip_on    = active_q[fnvcl_pkg::XIP_MSB:fnvcl_pkg::XIP_LSB]
	                   <= fnvcl_pkg::XIP_LAST_VALID;
	assign link_busy = link_q != FNVCL_LK_IDLE;

	// Lines in use: the protocol forces all phases, otherwise the dual and quad I/O variants widen the address phase.
	always_comb begin
		lines = 3'd1;
		unique case (fnvcl_pkg::fnvcl_proto_t'(protocol_out))
			fnvcl_pkg::FNVCL_PROTO_FOUR: lines = 3'd4;
			fnvcl_pkg::FNVCL_PROTO_TWO:  lines = 3'd2;
			default: begin
				if (link_q == FNVCL_LK_ADDR && variant_q == fnvcl_pkg::FNVCL_RD_QUAD_IO) begin
					lines = 3'd4;
				end else if (link_q == FNVCL_LK_ADDR &&
				             variant_q == fnvcl_pkg::FNVCL_RD_DUAL_IO) begin
					lines = 3'd2;
				end
			end
		endcase
		cmd_clks   = 5'(fnvcl_pkg::CMD_BITS / int'(lines));
		addr_clks  = 5'(fnvcl_pkg::ADDR_BITS / int'(lines));
		shift_next = (lines == 3'd4) ? {shift_q[3:0], dq_s} :
		             (lines == 3'd2) ? {shift_q[5:0], dq_s[1:0]} : {shift_q[6:0], dq_s[0]};
	end

	assign op = shift_next;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sclk_prev_q <= 1'b0;
		end else if (ce_in) begin
			sclk_prev_q <= sclk_s;
		end
	end

	// Working configuration is copied once when the loader leaves reset.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			active_q           <= fnvcl_pkg::NV_DEFAULT;
			dummy_count_out    <= fnvcl_pkg::DUMMY_MAX;
			xip_mode_out       <= 3'h7;
			drive_strength_out <= 3'h7;
			hold_enable_out    <= 1'b1;
			protocol_out       <= 2'h0;
		end else if (ce_in && por_q == FNVCL_POR_LOAD) begin
			active_q           <= nv_sync_q[15:0];
			dummy_count_out    <= fnvcl_pkg::dummy_decode(
			                      nv_sync_q[fnvcl_pkg::DUMMY_MSB:fnvcl_pkg::DUMMY_LSB]);
			xip_mode_out       <= nv_sync_q[fnvcl_pkg::XIP_MSB:fnvcl_pkg::XIP_LSB];
			drive_strength_out <= nv_sync_q[fnvcl_pkg::DRIVE_MSB:fnvcl_pkg::DRIVE_LSB];
			hold_enable_out    <= nv_sync_q[fnvcl_pkg::HOLD_EN_BIT];
			protocol_out       <= fnvcl_pkg::proto_decode(nv_sync_q[15:0]);
		end
	end

	// The load waits two cycles so that the synchroniser holds the stored word.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			por_q   <= FNVCL_POR_LOAD;
			timer_q <= 22'h0;
		end else if (ce_in) begin
			unique case (por_q)
				FNVCL_POR_LOAD: begin
					timer_q <= timer_q + 22'h1;
					if (timer_q == 22'h2) begin
						por_q   <= FNVCL_POR_BOOT;
						timer_q <= 22'h0;
					end
				end
				FNVCL_POR_BOOT: begin
					timer_q <= timer_q + 22'h1;
					if (!active_q[fnvcl_pkg::FAST_POR_BIT] &&
					    timer_q == 22'(fnvcl_pkg::FAST_POR_CYCLES - 1)) begin
						por_q   <= FNVCL_POR_RDONLY;
						timer_q <= 22'h0;
					end else if (active_q[fnvcl_pkg::FAST_POR_BIT] &&
					             timer_q == 22'(POR_FULL_CYCLES - 1)) begin
						por_q   <= FNVCL_POR_FULL;
						timer_q <= 22'h0;
					end
				end
				FNVCL_POR_RDONLY: begin
					// The shifter already holds the whole instruction the cycle after the accept.
					if (cmd_accept_out && shift_q == OP_WRITE_ENABLE &&
					    link_q == FNVCL_LK_SKIP) begin
						por_q <= FNVCL_POR_SECOND;
					end
				end
				FNVCL_POR_SECOND: begin
					timer_q <= timer_q + 22'h1;
					if (timer_q == 22'(POR_SECOND_CYCLES - 1)) begin
						por_q   <= FNVCL_POR_FULL;
						timer_q <= 22'h0;
					end
				end
				FNVCL_POR_FULL: begin
					timer_q <= 22'h0;
				end
			endcase
		end
	end

	// Serial front end: instruction, address, dummy clocks, then read data.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			link_q         <= FNVCL_LK_IDLE;
			variant_q      <= fnvcl_pkg::FNVCL_RD_SINGLE;
			bit_cnt_q      <= 5'h0;
			shift_q        <= 8'h0;
			cmd_accept_out <= 1'b0;
			cmd_reject_out <= 1'b0;
			read_data_out  <= 1'b0;
		end else if (ce_in) begin
			cmd_accept_out <= 1'b0;
			cmd_reject_out <= 1'b0;
			if (cs_n_s) begin
				link_q        <= FNVCL_LK_IDLE;
				read_data_out <= 1'b0;
				bit_cnt_q     <= 5'h0;
			end else begin
				unique case (link_q)
					FNVCL_LK_IDLE: begin
						if (cs_fall && por_q != FNVCL_POR_LOAD) begin
							if (xip_on && (por_q == FNVCL_POR_RDONLY ||
							               por_q == FNVCL_POR_FULL)) begin
								link_q    <= FNVCL_LK_ADDR;
								variant_q <= fnvcl_pkg::fnvcl_read_t'(xip_mode_out);
							end else begin
								link_q <= FNVCL_LK_CMD;
							end
						end
					end
					FNVCL_LK_CMD: begin
						if (sclk_rise) begin
							shift_q   <= shift_next;
							bit_cnt_q <= bit_cnt_q + 5'h1;
							if (bit_cnt_q == cmd_clks - 5'h1) begin
								bit_cnt_q <= 5'h0;
								link_q    <= FNVCL_LK_SKIP;
								cmd_reject_out <= 1'b1;
								if ((op == OP_STATUS_READ || op == OP_FLAG_READ) &&
								    por_q != FNVCL_POR_BOOT) begin
									link_q         <= FNVCL_LK_DATA;
									cmd_reject_out <= 1'b0;
									cmd_accept_out <= 1'b1;
								end else if (por_q == FNVCL_POR_SECOND ||
								             por_q == FNVCL_POR_BOOT) begin
									link_q <= FNVCL_LK_SKIP;
								end else if (op == OP_WRITE_ENABLE) begin
									cmd_reject_out <= 1'b0;
									cmd_accept_out <= 1'b1;
								end else if (op >= OP_SINGLE_FAST && op <= OP_QUAD_IO) begin
									link_q         <= FNVCL_LK_ADDR;
									variant_q      <= fnvcl_pkg::fnvcl_read_t'(op[2:0]);
									cmd_reject_out <= 1'b0;
									cmd_accept_out <= 1'b1;
								end else if (por_q == FNVCL_POR_FULL) begin
									cmd_reject_out <= 1'b0;
									cmd_accept_out <= 1'b1;
								end
							end
						end
					end
					FNVCL_LK_ADDR: begin
						if (sclk_rise) begin
							bit_cnt_q <= bit_cnt_q + 5'h1;
							if (bit_cnt_q == addr_clks - 5'h1) begin
								bit_cnt_q <= 5'h0;
								link_q    <= FNVCL_LK_DUMMY;
							end
						end
					end
					FNVCL_LK_DUMMY: begin
						if (dummy_done) begin
							link_q        <= FNVCL_LK_DATA;
							read_data_out <= 1'b1;
						end
					end
					FNVCL_LK_DATA: begin
						read_data_out <= 1'b1;
					end
					FNVCL_LK_SKIP: begin
						link_q <= FNVCL_LK_SKIP;
					end
					default: begin
						link_q <= FNVCL_LK_IDLE;
					end
				endcase
			end
		end
	end

	assign dummy_start = link_q == FNVCL_LK_ADDR && sclk_rise && bit_cnt_q == addr_clks - 5'h1;

	fnvcl_dummy_timer u_dummy (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.ce_in      (ce_in),
		.start_in   (dummy_start),
		.tick_in    (sclk_rise && link_q == FNVCL_LK_DUMMY),
		.count_in   (dummy_count_out),
		.done_out   (dummy_done),
		.busy_out   ()
	);

	// Serial clock period in system clocks, measured between rising edges.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			period_cnt_q <= 8'h0;
			period_q     <= 8'hff;
		end else if (ce_in) begin
			if (cs_n_s) begin
				period_cnt_q <= 8'h0;
				period_q     <= 8'hff;
			end else if (sclk_rise) begin
				period_cnt_q <= 8'h1;
				if (period_cnt_q != 8'h0) begin
					period_q <= period_cnt_q;
				end
			end else if (period_cnt_q != 8'hff && period_cnt_q != 8'h0) begin
				period_cnt_q <= period_cnt_q + 8'h1;
			end
		end
	end

	assign tbl_idx  = (dummy_count_out > 4'(fnvcl_pkg::TABLE_DUMMY_MAX)) ?
	                  4'(fnvcl_pkg::TABLE_DUMMY_MAX - 1) : dummy_count_out - 4'h1;
	assign limit_ns = 22'(int'(period_q) * fnvcl_pkg::CLK_PERIOD_NS) *
	                  22'(fnvcl_pkg::FREQ_LIMIT[variant_q][tbl_idx]);

	// Dummy count too small for the measured clock marks the read as corrupted.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			overclock_q      <= 1'b0;
			read_corrupt_out <= 1'b0;
		end else if (ce_in) begin
			if (dummy_done && limit_ns < 22'd1000) begin
				overclock_q      <= 1'b1;
				read_corrupt_out <= 1'b1;
			end else if (reg_wr_in && reg_addr_in == fnvcl_pkg::OFS_STATUS &&
			             reg_wdata_in[fnvcl_pkg::ST_OVERCLOCK]) begin
				overclock_q <= 1'b0;
			end
			if (cs_n_s) begin
				read_corrupt_out <= 1'b0;
			end
		end
	end

	// Hold through data line three only when enabled and the line is not data.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hold_active_out <= 1'b0;
		end else if (ce_in) begin
			hold_active_out <= hold_enable_out && !cs_n_s && !dq_s[3] && lines != 3'd4 &&
			                   protocol_out == 2'(fnvcl_pkg::FNVCL_PROTO_EXT) &&
			                   link_busy;
		end
	end

	// Register port: the new word reaches the array but acts only after a reset.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			nv_q               <= fnvcl_pkg::NV_DEFAULT;
			nv_program_out     <= fnvcl_pkg::NV_DEFAULT;
			nv_program_stb_out <= 1'b0;
			reg_rdata_out      <= 16'h0;
		end else if (ce_in) begin
			nv_program_stb_out <= 1'b0;
			if (por_q == FNVCL_POR_LOAD) begin
				nv_q <= nv_sync_q[15:0];
			end else if (reg_wr_in && reg_addr_in == fnvcl_pkg::OFS_NV_WORD) begin
				nv_q               <= reg_wdata_in;
				nv_program_out     <= reg_wdata_in;
				nv_program_stb_out <= 1'b1;
			end
			reg_rdata_out <= 16'h0;
			if (reg_rd_in) begin
				unique case (reg_addr_in)
					fnvcl_pkg::OFS_NV_WORD: reg_rdata_out <= nv_q;
					fnvcl_pkg::OFS_ACTIVE:  reg_rdata_out <= active_q;
					fnvcl_pkg::OFS_STATUS:  reg_rdata_out <= {11'h0, xip_on, overclock_q,
					                        por_q == FNVCL_POR_SECOND, por_q == FNVCL_POR_FULL,
					                        por_q == FNVCL_POR_RDONLY || por_q == FNVCL_POR_FULL};
					default:                reg_rdata_out <= 16'h0;
				endcase
			end
		end
	end

endmodule : fnvcl_config_loader

// file: core/fnvcl_dummy_timer.sv
`timescale 1ns/1ns
module fnvcl_dummy_timer (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	input  wire logic       ce_in,
	// Control
	input  wire logic       start_in,
	input  wire logic       tick_in,
	input  wire logic [3:0] count_in,
	// Result
	output logic            done_out,
	output logic            busy_out
);

	logic [3:0] remain_q;

	// Done pulses the cycle after the tick that completes exactly count_in serial clocks.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			remain_q <= 4'h0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end else if (ce_in) begin
			done_out <= 1'b0;
			if (start_in) begin
				remain_q <= count_in;
				busy_out <= 1'b1;
			end else if (busy_out && tick_in) begin
				remain_q <= remain_q - 4'h1;
				if (remain_q == 4'h1) begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
				end
			end
		end
	end

endmodule : fnvcl_dummy_timer

// file: inc/fnvcl_pkg.sv
// Overview of operation
// - Word bits 15..12 give the power-on dummy clock count for all fast reads.
// - Dummy counts one to fifteen insert exactly that many serial clocks before data.
// - Shipped dummy count works for every fast read at the top clock rate.
// - Too few dummy clocks for the clock rate is flagged as corrupted read data.
// - Bits 11..9 select execute-in-place at power-on; address only, no instruction.
// - Shipped execute-in-place code leaves it off, standard extended protocol.
// - Bits 8..6 hold drive strength; shipped code selects thirty ohms.
// - Fast power-on enabled: first read accepted under one hundred microseconds.
// - In fast power-on, first write enable starts a second phase of about 500 us.
// - During the second phase only status and flag status polls are accepted.
// - Fast power-on off: full 500 us start-up, no extra write enable latency.
// - Bit 4 gates the hold function of data line three.
// - Bit 3 low selects the four-line protocol from the next power-on.
// - Bit 2 low selects the two-line protocol from the next power-on.
// - Both bits low gives the four-line protocol priority.
// - Dummy code 0000 behaves exactly like 1111.
// - Fast power-on bit is active low; during its short phase only reads and write enable work.
// - Hold gating bit: zero disables the pin function, one enables it.
package fnvcl_pkg;

	localparam int          DATA_W          = 16;
	localparam int          ADDR_W          = 4;
	localparam logic [3:0]  OFS_NV_WORD     = 4'h0;
	localparam logic [3:0]  OFS_ACTIVE      = 4'h4;
	localparam logic [3:0]  OFS_STATUS      = 4'h8;
	localparam logic [15:0] NV_DEFAULT      = 16'hffff;
	localparam int          DUMMY_MSB       = 15;
	localparam int          DUMMY_LSB       = 12;
	localparam int          XIP_MSB         = 11;
	localparam int          XIP_LSB         = 9;
	localparam int          DRIVE_MSB       = 8;
	localparam int          DRIVE_LSB       = 6;
	localparam int          FAST_POR_BIT    = 5;
	localparam int          HOLD_EN_BIT     = 4;
	localparam int          QUAD_BIT        = 3;
	localparam int          DUAL_BIT        = 2;
	localparam int          ST_READ_OK      = 0;
	localparam int          ST_MODIFY_OK    = 1;
	localparam int          ST_SECOND       = 2;
	localparam int          ST_OVERCLOCK    = 3;
	localparam int          ST_XIP          = 4;
	localparam logic [2:0]  XIP_LAST_VALID  = 3'h4;
	localparam logic [3:0]  DUMMY_MAX       = 4'hf;
	localparam int          TABLE_DUMMY_MAX = 10;

	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          FAST_POR_US     = 100;
	localparam int          FULL_POR_US     = 500;
	localparam int          FAST_POR_CYCLES = FAST_POR_US * 1000 / CLK_PERIOD_NS - 1;
	localparam int          FULL_POR_CYCLES = FULL_POR_US * 1000 / CLK_PERIOD_NS;
	localparam int          ADDR_BITS       = 24;
	localparam int          CMD_BITS        = 8;

	typedef enum logic [1:0] {
		FNVCL_PROTO_EXT  = 2'h0,
		FNVCL_PROTO_TWO  = 2'h1,
		FNVCL_PROTO_FOUR = 2'h2
	} fnvcl_proto_t;

	// Fast read variants, same order as the execute-in-place codes.
	typedef enum logic [2:0] {
		FNVCL_RD_SINGLE = 3'h0,
		FNVCL_RD_DUAL_O = 3'h1,
		FNVCL_RD_DUAL_IO = 3'h2,
		FNVCL_RD_QUAD_O = 3'h3,
		FNVCL_RD_QUAD_IO = 3'h4
	} fnvcl_read_t;

	// Highest serial clock in MHz per variant, for dummy counts one to ten.
	localparam logic [7:0] FREQ_LIMIT [0:4][0:9] = '{
		'{8'd50, 8'd95, 8'd105, 8'd108, 8'd108, 8'd108, 8'd108, 8'd108, 8'd108, 8'd108},
		'{8'd50, 8'd85, 8'd95, 8'd105, 8'd108, 8'd108, 8'd108, 8'd108, 8'd108, 8'd108},
		'{8'd39, 8'd59, 8'd75, 8'd88, 8'd94, 8'd105, 8'd108, 8'd108, 8'd108, 8'd108},
		'{8'd43, 8'd56, 8'd70, 8'd83, 8'd94, 8'd105, 8'd108, 8'd108, 8'd108, 8'd108},
		'{8'd20, 8'd39, 8'd49, 8'd59, 8'd69, 8'd78, 8'd86, 8'd95, 8'd105, 8'd108}
	};

	function automatic logic [3:0] dummy_decode(input logic [3:0] code);
		dummy_decode = (code == 4'h0) ? DUMMY_MAX : code;
	endfunction : dummy_decode

	function automatic fnvcl_proto_t proto_decode(input logic [15:0] word);
		if (!word[QUAD_BIT]) begin
			proto_decode = FNVCL_PROTO_FOUR;
		end else if (!word[DUAL_BIT]) begin
			proto_decode = FNVCL_PROTO_TWO;
		end else begin
			proto_decode = FNVCL_PROTO_EXT;
		end
	endfunction : proto_decode

endpackage : fnvcl_pkg

// file: tb/fnvcl_config_loader_asserts.sv
`timescale 1ns/1ns
module fnvcl_config_loader_asserts (
	// Clock and reset
	input wire logic        clk_in,
	input wire logic        reset_n_in,
	// Register port
	input wire logic [3:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic [15:0] nv_program_out,
	input wire logic        nv_program_stb_out,
	// Link and working set
	input wire logic        cs_n_in,
	input wire logic [3:0]  dummy_count_out,
	input wire logic        hold_enable_out,
	input wire logic [1:0]  protocol_out,
	input wire logic        hold_active_out,
	input wire logic        cmd_accept_out,
	input wire logic        cmd_reject_out,
	input wire logic        read_data_out,
	input wire logic        read_corrupt_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	logic [2:0] age_q;
	// Counts cycles since reset so the load window is skipped.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			age_q <= 3'h0;
		end else if (age_q != 3'h7) begin
			age_q <= age_q + 3'h1;
		end
	end
	chk_cfg_frozen: assert property (age_q == 3'h7 |->
		$stable({dummy_count_out, hold_enable_out, protocol_out})) else $error("config moved");
	chk_dummy_nonzero: assert property (dummy_count_out != 4'h0)
		else $error("dummy count zero");
	chk_hold_gated: assert property (hold_active_out |->
		hold_enable_out && protocol_out == 2'h0) else $error("hold not gated");
	chk_pulse_excl: assert property (cmd_accept_out |->
		!cmd_reject_out ##1 !cmd_accept_out) else $error("accept pulse bad");
	chk_prog_strobe: assert property (reg_wr_in && reg_addr_in == 4'h0 && age_q == 3'h7
		|=> nv_program_stb_out && nv_program_out == $past(reg_wdata_in)) else $error("no program");
	chk_stb_cause: assert property (nv_program_stb_out |->
		$past(reg_wr_in) && $past(reg_addr_in) == 4'h0) else $error("stray program");
	chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0)
		else $error("read data not idle");
	chk_read_release: assert property (cs_n_in [*8] |->
		!read_data_out && !read_corrupt_out) else $error("read not released");
	cover property (cmd_accept_out);
	cover property (cmd_reject_out);
	cover property ($rose(read_data_out));
	cover property (hold_active_out);
endmodule : fnvcl_config_loader_asserts

bind fnvcl_config_loader fnvcl_config_loader_asserts fnvcl_config_loader_asserts_inst (
	.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .nv_program_out(nv_program_out),
	.nv_program_stb_out(nv_program_stb_out), .cs_n_in(cs_n_in),
	.dummy_count_out(dummy_count_out), .hold_enable_out(hold_enable_out),
	.protocol_out(protocol_out), .hold_active_out(hold_active_out),
	.cmd_accept_out(cmd_accept_out), .cmd_reject_out(cmd_reject_out),
	.read_data_out(read_data_out), .read_corrupt_out(read_corrupt_out));

// file: tb/fnvcl_config_loader_tb_top.sv
`timescale 1ns/1ns
module fnvcl_config_loader_tb_top;
	localparam logic [15:0] CORNER [6] = '{16'h0000, 16'hfffb, 16'hfff7, 16'hffef,
		16'h1fff, 16'hf1ff};
	logic        clk_in = 1'b0;
	logic        reset_n_in, ce_in, reg_wr_in, reg_rd_in, sclk, cs_n;
	logic [3:0]  reg_addr_in, dq, dummy_count_out;
	logic [15:0] reg_wdata_in, reg_rdata_out, nv_store_in, nv_program_out, w;
	logic [2:0]  xip_mode_out, drive_strength_out;
	logic [1:0]  protocol_out;
	logic        hold_enable_out, hold_active_out, cmd_accept_out, cmd_reject_out;
	logic        read_data_out, read_corrupt_out;
	int          fails = 0, num_checks = 0, acc_n = 0, rej_n = 0, seed = 25108;
	wire  [15:0] cfg = {3'h0, dummy_count_out, xip_mode_out, drive_strength_out,
		hold_enable_out, protocol_out};
	always #50 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		acc_n += int'(cmd_accept_out === 1'b1);
		rej_n += int'(cmd_reject_out === 1'b1);
	end
	fnvcl_host_model host_inst (.sclk_out(sclk), .cs_n_out(cs_n), .dq_out(dq));
	fnvcl_config_loader #(.POR_FULL_CYCLES(50), .POR_SECOND_CYCLES(2000))
	fnvcl_config_loader_inst (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .nv_store_in(nv_store_in),
		.nv_program_out(nv_program_out), .nv_program_stb_out(), .sclk_in(sclk),
		.cs_n_in(cs_n), .dq_in(dq), .dummy_count_out(dummy_count_out),
		.xip_mode_out(xip_mode_out), .drive_strength_out(drive_strength_out),
		.hold_enable_out(hold_enable_out), .protocol_out(protocol_out),
		.hold_active_out(hold_active_out), .cmd_accept_out(cmd_accept_out),
		.cmd_reject_out(cmd_reject_out), .read_data_out(read_data_out),
		.read_corrupt_out(read_corrupt_out));
	function automatic logic [15:0] exp_cfg(input logic [15:0] v);
		logic [1:0] p;
		p = !v[3] ? 2'h2 : (!v[2] ? 2'h1 : 2'h0);
		return {3'h0, (v[15:12] == 4'h0) ? 4'hf : v[15:12], v[11:6], v[4], p};
	endfunction : exp_cfg
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task end_of_test;
		if (fails == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	task boot(input logic [15:0] v, input int n);
		@(posedge clk_in);
		nv_store_in <= v;
		reset_n_in  <= 1'b0;
		repeat (n) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (8) @(posedge clk_in);
	endtask : boot
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_in);
		chk(reg_rdata_out, e);
	endtask : rd
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task frame(input logic [7:0] op);
		host_inst.clocks(8, op);
		host_inst.stop();
	endtask : frame
	task do_read(input int n);
		host_inst.clocks(8, 8'h10);
		host_inst.clocks(23 + n, 8'h00);
		chk({15'h0, read_data_out}, 16'h0);
		host_inst.clocks(1, 8'h00);
		#800;
		chk({14'h0, read_corrupt_out, read_data_out}, 16'h1);
		host_inst.stop();
		chk({15'h0, read_data_out}, 16'h0);
	endtask : do_read
	initial begin
		#3000000;
		fails++;
		end_of_test();
	end
	initial begin
		{reset_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
		ce_in       = 1'b1;
		nv_store_in = 16'hffff;
		boot(16'hffff, 16);
		chk(cfg, exp_cfg(16'hffff));
		rd(4'h2, 16'h0000);
		repeat (60) @(posedge clk_in);
		rd(4'h8, 16'h0003);
		wr(4'h0, 16'h1e7b);
		rd(4'h0, 16'h1e7b);
		chk(nv_program_out, 16'h1e7b);
		rd(4'h4, 16'hffff);
		do_read(15);
		frame(8'h01);
		rd(4'h8, 16'h0003);
		host_inst.clocks(8, 8'h02);
		host_inst.dq_out[3] = 1'b0;
		#600;
		chk({15'h0, hold_active_out}, 16'h1);
		host_inst.dq_out[3] = 1'b1;
		host_inst.stop();
		for (int i = 0; i < 12; i++) begin
			w = (i < 6) ? CORNER[i] : 16'($random(seed));
			boot(w, 2);
			chk(cfg, exp_cfg(w));
			rd(4'h4, w);
		end
		wr(4'h4, 16'h0000);
		rd(4'h4, w);
		boot(16'h1fff, 2);
		ce_in <= 1'b0;
		repeat (60) @(posedge clk_in);
		ce_in <= 1'b1;
		rd(4'h8, 16'h0000);
		repeat (60) @(posedge clk_in);
		do_read(1);
		boot(16'hffdf, 2);
		rd(4'h8, 16'h0000);
		frame(8'h10);
		repeat (1000) @(posedge clk_in);
		rd(4'h8, 16'h0001);
		do_read(15);
		frame(8'h01);
		rd(4'h8, 16'h0004);
		frame(8'h10);
		frame(8'h03);
		repeat (2000) @(posedge clk_in);
		rd(4'h8, 16'h0003);
		boot(16'hf1ff, 2);
		repeat (60) @(posedge clk_in);
		rd(4'h8, 16'h0013);
		do_read(7);
		chk({8'(acc_n), 8'(rej_n)}, 16'h0702);
		end_of_test();
	end
endmodule : fnvcl_config_loader_tb_top

// file: tb/fnvcl_host_model.sv
`timescale 1ns/1ns
module fnvcl_host_model (
	// Serial pins
	output logic       sclk_out,
	output logic       cs_n_out,
	output logic [3:0] dq_out
);
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		dq_out   = 4'h9;
	end
	// Clock stands low between frames; line three is driven high while clocking so no hold is entered, and stop inverts it.
	task clocks(input int n, input logic [7:0] b);
		#37;
		for (int i = 0; i < n; i++) begin
			cs_n_out = 1'b0;
			dq_out   = {1'b1, 2'(i), b[7 - (i % 8)]};
			#400 sclk_out = 1'b1;
			#400 sclk_out = 1'b0;
		end
	endtask : clocks
	task stop;
		cs_n_out = 1'b1;
		dq_out   = ~dq_out;
		#800;
	endtask : stop
endmodule : fnvcl_host_model
